// ### design/ccc_consts.vh
// Register map, field positions and mode codes of the capture and compare channel pair.
`ifndef CCC_CONSTS_VH
`define CCC_CONSTS_VH
// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define CCC_ADR_CAP_CTRL 8'h00
`define CCC_ADR_CAP_DATA 8'h04
`define CCC_ADR_CMP_CTRL 8'h08
`define CCC_ADR_CMP_PRI 8'h0c
`define CCC_ADR_CMP_SEC 8'h10
`define CCC_ADR_STATUS 8'h14
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CCC_BIT_SIDL 13
`define CCC_BIT_CAP_TMR 7
`define CCC_BIT_CPI_HI 6
`define CCC_BIT_CPI_LO 5
`define CCC_BIT_CAP_OV 4
`define CCC_BIT_CAP_BNE 3
`define CCC_BIT_FLT 4
`define CCC_BIT_CMP_TSEL 3
`define CCC_BIT_STS_CAPIRQ 0
`define CCC_BIT_STS_CMPIRQ 1
`define CCC_BIT_STS_PIN 2
// ------------------------------------------------------------
// Capture modes
// ------------------------------------------------------------
`define CCC_CM_OFF 3'h0
`define CCC_CM_EDGE 3'h1
`define CCC_CM_FALL 3'h2
`define CCC_CM_RISE 3'h3
`define CCC_CM_RISE4 3'h4
`define CCC_CM_RISE16 3'h5
`define CCC_CM_WAKE 3'h7
// ------------------------------------------------------------
// Compare modes
// ------------------------------------------------------------
`define CCC_OM_OFF 3'h0
`define CCC_OM_SETHI 3'h1
`define CCC_OM_SETLO 3'h2
`define CCC_OM_TOGGLE 3'h3
`define CCC_OM_ONESHOT 3'h4
`define CCC_OM_PULSES 3'h5
`define CCC_OM_PWM 3'h6
`define CCC_OM_PWMF 3'h7
// ------------------------------------------------------------
// Sizes and counts
// ------------------------------------------------------------
`define CCC_FIFO_DEPTH 3'h4
`define CCC_PRE4_LAST 4'h3
`define CCC_PRE16_LAST 4'hf
`endif

// ### design/ccc_capture_compare.v
// Timer-based input capture channel and output compare channel with a Wishbone register slave.
//
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`include "ccc_consts.vh"

module ccc_capture_compare (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave.
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // Time bases and power state.
  input wire [15:0] timer_a_count_i,
  input wire [15:0] timer_b_count_i,
  input wire cpu_idle_i,
  input wire cpu_sleep_i,
  // Pins.
  input wire capture_input_pin_i,
  input wire compare_fault_input_i,
  input wire port_data_i,
  output reg compare_output_pin_o,
  // Event pulses.
  output reg capture_irq_o,
  output reg compare_irq_o
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Byte-lane merge used by the compare control, primary and secondary registers.
  function [15:0] ccc_merge;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] sel;
    begin
      ccc_merge = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  reg cap_sidl;
  reg cap_tsel;
  reg [1:0] cap_cpi;
  reg [2:0] cap_mode;
  reg cap_ov;
  reg cmp_sidl;
  reg cmp_tsel;
  reg [2:0] cmp_mode;
  reg cmp_flt;
  reg [15:0] pri_val;
  reg [15:0] sec_val;
  // Capture buffer. The count is one bit wider than the pointers so that a full
  // buffer and an empty one never look alike.
  reg [15:0] fifo_mem [0:3];
  reg [1:0] wr_ptr;
  reg [1:0] rd_ptr;
  reg [2:0] fifo_cnt;
  // Edge detectors start at the idle level of their pin, so no false edge follows reset.
  reg pin_q;
  reg flt_q;
  reg [3:0] pre_cnt;
  reg [1:0] irq_cnt;
  reg cmp_done;
  reg cmp_out;
  reg cap_irq_flag;
  reg cmp_irq_flag;

  // Bus decode. The registered ack masks the second cycle of the same strobe,
  // so a request held until its answer is taken exactly once.
  wire bus_req = cyc_i & stb_i & ~ack_o;
  wire bus_wr = bus_req & we_i;
  wire bus_rd = bus_req & ~we_i;
  wire wr_cap = bus_wr & (adr_i == `CCC_ADR_CAP_CTRL);
  wire wr_cmp = bus_wr & (adr_i == `CCC_ADR_CMP_CTRL);
  wire rd_data = bus_rd & (adr_i == `CCC_ADR_CAP_DATA);
  wire rd_status = bus_rd & (adr_i == `CCC_ADR_STATUS);

  // ------------------------------------------------------------
  // Capture event detection
  // ------------------------------------------------------------
  wire cap_run = ~(cap_sidl & cpu_idle_i);
  // Rise and fall are seen at the first edge that samples the new pin level, against the held level.
  wire rise = capture_input_pin_i & ~pin_q;
  wire fall = ~capture_input_pin_i & pin_q;
  // The timer value is taken at the same edge that sees the pin change.
  wire [15:0] cap_time = cap_tsel ? timer_a_count_i : timer_b_count_i;
  wire fifo_empty = (fifo_cnt == 3'h0);
  wire fifo_full = (fifo_cnt == `CCC_FIFO_DEPTH);
  reg cap_evt;

  // Select the edge kind that makes a capture event.
  always @* begin
    cap_evt = 1'b0;
    case (cap_mode)
      `CCC_CM_EDGE: cap_evt = rise | fall;
      `CCC_CM_FALL: cap_evt = fall;
      `CCC_CM_RISE: cap_evt = rise;
      `CCC_CM_RISE4: cap_evt = rise & (pre_cnt[1:0] == `CCC_PRE4_LAST);
      `CCC_CM_RISE16: cap_evt = rise & (pre_cnt == `CCC_PRE16_LAST);
      default: cap_evt = 1'b0;
    endcase
    cap_evt = cap_evt & cap_run;
  end

  // A value taken while the buffer is full is lost; the overflow flag records it.
  wire cap_push = cap_evt & ~fifo_full;
  wire cap_pop = rd_data & ~fifo_empty;
  // Wake mode only flags rising edges while the CPU sleeps or idles.
  wire wake_evt = (cap_mode == `CCC_CM_WAKE) & rise & (cpu_sleep_i | cpu_idle_i);
  // The interrupt counter restarts on every capture control write, so a new
  // ratio never inherits a partial count from the old one.
  wire cpi_hit = cap_evt & (irq_cnt == cap_cpi);

  // Capture datapath: prescaler, FIFO, overflow and interrupt counting.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= 1'b0;
      pre_cnt <= 4'h0;
      irq_cnt <= 2'h0;
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      fifo_cnt <= 3'h0;
      cap_ov <= 1'b0;
    end else begin
      pin_q <= capture_input_pin_i;
      if (wr_cap) begin
        pre_cnt <= 4'h0;
        irq_cnt <= 2'h0;
      end else if (rise & cap_run) begin
        pre_cnt <= pre_cnt + 4'h1;
      end
      if (cap_evt & ~wr_cap) begin
        irq_cnt <= cpi_hit ? 2'h0 : irq_cnt + 2'h1;
      end
      if (cap_push) begin
        fifo_mem[wr_ptr] <= cap_time;
        wr_ptr <= wr_ptr + 2'h1;
      end
      if (cap_pop) begin
        rd_ptr <= rd_ptr + 2'h1;
      end
      // A push and a pop in one cycle leave the count unchanged.
      fifo_cnt <= fifo_cnt + {2'h0, cap_push} - {2'h0, cap_pop};
      // A full FIFO drops the new value; the flag clears once emptied or mode off.
      if (cap_evt & fifo_full) begin
        cap_ov <= 1'b1;
      end else if ((fifo_empty & ~cap_push) | (cap_mode == `CCC_CM_OFF)) begin
        cap_ov <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Compare channel
  // ------------------------------------------------------------
  // Matches are gated by the idle halt, so a stopped channel never moves its pin on a match
  // and never raises a match event, even while its time base keeps counting.
  wire cmp_run = ~(cmp_sidl & cpu_idle_i);
  wire [15:0] cmp_time = cmp_tsel ? timer_b_count_i : timer_a_count_i;
  wire hit_pri = cmp_run & (cmp_time == pri_val);
  wire hit_sec = cmp_run & (cmp_time == sec_val);
  wire flt_fall = ~compare_fault_input_i & flt_q;
  // The old value is rebuilt at full register width so the idle bit keeps its position.
  wire [15:0] next_ctrl = ccc_merge({2'h0, cmp_sidl, 9'h000, cmp_tsel, cmp_mode}, dat_i, sel_i);
  wire [2:0] next_mode = next_ctrl[2:0];
  // Limitation: the PWM period is taken as the wrap of the selected time base to zero.
  wire pwm_init = (pri_val != 16'h0000);
  reg next_out;
  reg next_done;
  reg cmp_evt;

  // Next output level per mode; writes of the control register re-initialise the pin, except in toggle mode, which keeps its level.
  always @* begin
    next_out = cmp_out;
    next_done = cmp_done;
    cmp_evt = 1'b0;
    // A control write takes priority over a match in the same cycle; the time
    // base is expected to be stopped then, so no match is lost in practice.
    if (wr_cmp) begin
      next_done = 1'b0;
      case (next_mode)
        `CCC_OM_SETLO: next_out = 1'b1;
        `CCC_OM_TOGGLE: next_out = cmp_out;
        `CCC_OM_PWM: next_out = pwm_init;
        `CCC_OM_PWMF: next_out = pwm_init;
        default: next_out = 1'b0;
      endcase
    end else begin
      case (cmp_mode)
        `CCC_OM_SETHI: begin
          if (hit_pri & ~cmp_out) begin
            next_out = 1'b1;
            cmp_evt = 1'b1;
          end
        end
        `CCC_OM_SETLO: begin
          if (hit_pri & cmp_out) begin
            next_out = 1'b0;
            cmp_evt = 1'b1;
          end
        end
        `CCC_OM_TOGGLE: begin
          if (hit_pri) begin
            next_out = ~cmp_out;
            cmp_evt = 1'b1;
          end
        end
        `CCC_OM_ONESHOT: begin
          if (~cmp_done & ~cmp_out & hit_pri) begin
            next_out = 1'b1;
          end else if (cmp_out & hit_sec) begin
            next_out = 1'b0;
            next_done = 1'b1;
            cmp_evt = 1'b1;
          end
        end
        `CCC_OM_PULSES: begin
          if (~cmp_out & hit_pri) begin
            next_out = 1'b1;
          end else if (cmp_out & hit_sec) begin
            next_out = 1'b0;
            cmp_evt = 1'b1;
          end
        end
        `CCC_OM_PWM, `CCC_OM_PWMF: begin
          // Period restarts the pulse; secondary value ends it.
          if (cmp_run & (cmp_time == 16'h0000)) begin
            next_out = pwm_init;
          end else if (hit_sec) begin
            next_out = 1'b0;
          end
          if ((cmp_mode == `CCC_OM_PWMF) & (cmp_flt | ~compare_fault_input_i)) begin
            next_out = 1'b0;
          end
          cmp_evt = (cmp_mode == `CCC_OM_PWMF) & flt_fall;
        end
        default: next_out = cmp_out;
      endcase
    end
  end

  // Compare state and fault latch; only a control write clears the fault.
  always @(posedge clk_i) begin
    if (rst_i) begin
      cmp_out <= 1'b0;
      cmp_done <= 1'b0;
      flt_q <= 1'b1;
      cmp_flt <= 1'b0;
    end else begin
      flt_q <= compare_fault_input_i;
      cmp_out <= next_out;
      cmp_done <= next_done;
      // A fault still present at a control write keeps the flag: the set wins.
      if ((cmp_mode == `CCC_OM_PWMF) & ~compare_fault_input_i) begin
        cmp_flt <= 1'b1;
      end else if (wr_cmp) begin
        cmp_flt <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Pins and event outputs
  // ------------------------------------------------------------
  // The pin follows the port latch when disabled so software keeps control of it.
  always @(posedge clk_i) begin
    if (rst_i) begin
      compare_output_pin_o <= 1'b0;
      capture_irq_o <= 1'b0;
      compare_irq_o <= 1'b0;
    end else begin
      compare_output_pin_o <= (cmp_mode == `CCC_OM_OFF) ? port_data_i : next_out;
      capture_irq_o <= cpi_hit | wake_evt;
      compare_irq_o <= cmp_evt;
    end
  end

  // ------------------------------------------------------------
  // Register slave
  // ------------------------------------------------------------
  // Control writes; sticky event bits in the status register, set wins over clear.
  always @(posedge clk_i) begin
    if (rst_i) begin
      cap_sidl <= 1'b0;
      cap_tsel <= 1'b0;
      cap_cpi <= 2'h0;
      cap_mode <= 3'h0;
      cmp_sidl <= 1'b0;
      cmp_tsel <= 1'b0;
      cmp_mode <= 3'h0;
      pri_val <= 16'h0000;
      sec_val <= 16'h0000;
      cap_irq_flag <= 1'b0;
      cmp_irq_flag <= 1'b0;
    end else begin
      // Each byte lane updates only the fields that live in it.
      if (wr_cap) begin
        cap_sidl <= sel_i[1] ? dat_i[`CCC_BIT_SIDL] : cap_sidl;
        cap_tsel <= sel_i[0] ? dat_i[`CCC_BIT_CAP_TMR] : cap_tsel;
        cap_cpi <= sel_i[0] ? dat_i[`CCC_BIT_CPI_HI:`CCC_BIT_CPI_LO] : cap_cpi;
        cap_mode <= sel_i[0] ? dat_i[2:0] : cap_mode;
      end
      if (wr_cmp) begin
        cmp_sidl <= next_ctrl[`CCC_BIT_SIDL];
        cmp_tsel <= next_ctrl[`CCC_BIT_CMP_TSEL];
        cmp_mode <= next_mode;
      end
      if (bus_wr & (adr_i == `CCC_ADR_CMP_PRI)) begin
        pri_val <= ccc_merge(pri_val, dat_i, sel_i);
      end
      if (bus_wr & (adr_i == `CCC_ADR_CMP_SEC)) begin
        sec_val <= ccc_merge(sec_val, dat_i, sel_i);
      end
      // Sticky event bits: an event in the cycle of a status read survives it.
      cap_irq_flag <= (cpi_hit | wake_evt) | (cap_irq_flag & ~rd_status);
      cmp_irq_flag <= cmp_evt | (cmp_irq_flag & ~rd_status);
    end
  end

  // Single-wait answer: ack one cycle after the request, dropped the next cycle.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      // Read data is zero outside the answer, so a stray sample shows nothing.
      ack_o <= bus_req;
      dat_o <= 32'h00000000;
      if (bus_rd) begin
        case (adr_i)
          `CCC_ADR_CAP_CTRL: dat_o <= {16'h0000, 2'h0, cap_sidl, 5'h00, cap_tsel, cap_cpi,
            cap_ov, ~fifo_empty, cap_mode};
          // An empty buffer reads zero rather than a word that was never written.
          `CCC_ADR_CAP_DATA: dat_o <= {16'h0000, fifo_empty ? 16'h0000 : fifo_mem[rd_ptr]};
          `CCC_ADR_CMP_CTRL: dat_o <= {16'h0000, 2'h0, cmp_sidl, 8'h00, cmp_flt, cmp_tsel,
            cmp_mode};
          `CCC_ADR_CMP_PRI: dat_o <= {16'h0000, pri_val};
          `CCC_ADR_CMP_SEC: dat_o <= {16'h0000, sec_val};
          `CCC_ADR_STATUS: dat_o <= {29'h00000000, compare_output_pin_o, cmp_irq_flag,
            cap_irq_flag};
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// ### verif/ccc_props.sv
// Concurrent checks on the ports of the capture and compare channel pair.
module ccc_props (
  // Clock, reset and bus.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Power state and pins.
  input wire logic cpu_idle_i,
  input wire logic cpu_sleep_i,
  input wire logic compare_fault_input_i,
  input wire logic compare_output_pin_o,
  input wire logic capture_irq_o,
  input wire logic compare_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cm;
  logic [2:0] om;
  logic [2:0] om_q;
  wire wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  wire st = (om == om_q);
  // Mode shadows move at the taking edge; st masks the cycle in which a mode changes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cm <= 3'h0;
      om <= 3'h0;
    end else if (wr && adr_i == 8'h00) begin
      cm <= dat_i[2:0];
    end else if (wr && adr_i == 8'h08) begin
      om <= dat_i[2:0];
    end
  end
  // Previous compare mode.
  always_ff @(posedge clk_i) begin
    om_q <= om;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");
  property p_dat_zero; !ack_o |-> dat_o == 32'h0; endproperty
  a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");
  property p_off_quiet; om == 3'h0 && st |-> !compare_irq_o; endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("event while disabled");
  property p_pwm_quiet; om == 3'h6 && st |-> !compare_irq_o; endproperty
  a_pwm_quiet: assert property (p_pwm_quiet) else $error("event in plain pwm");
  property p_rise_irq; compare_irq_o && om == 3'h1 && st |-> $rose(compare_output_pin_o);
  endproperty
  a_rise_irq: assert property (p_rise_irq) else $error("event without rise");
  property p_fall_irq;
    compare_irq_o && st && om inside {3'h2, 3'h4, 3'h5} |-> $fell(compare_output_pin_o);
  endproperty
  a_fall_irq: assert property (p_fall_irq) else $error("event without fall");
  property p_tog_irq; compare_irq_o && om == 3'h3 && st |-> $changed(compare_output_pin_o);
  endproperty
  a_tog_irq: assert property (p_tog_irq) else $error("toggle event without edge");
  property p_fault_low; (om == 3'h7 && !compare_fault_input_i) [*3] |=> !compare_output_pin_o;
  endproperty
  a_fault_low: assert property (p_fault_low) else $error("pin high under fault");
  property p_wake_only; (cm == 3'h7 && !cpu_sleep_i && !cpu_idle_i) [*3] |-> !capture_irq_o;
  endproperty
  a_wake_only: assert property (p_wake_only) else $error("wake event while awake");
  c_oneshot: cover property (compare_irq_o && om == 3'h4);
  c_wake: cover property (capture_irq_o && cm == 3'h7);
  c_fault: cover property (om == 3'h7 && !compare_fault_input_i);
endmodule

// ### verif/ccc_pin_model.sv
// Pin-side model: drives the capture pin and the active-low fault line.
module ccc_pin_model (
  // Clock.
  input wire logic clk_i,
  // Pins.
  output logic capture_input_pin_o,
  output logic compare_fault_input_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // The fault line idles high, as if pulled up.
  initial begin
    capture_input_pin_o = 1'b0;
    compare_fault_input_o = 1'b1;
  end
  // Both levels are held four cycles so the synchronous sampler sees every edge.
  task automatic pulses(input int n);
    repeat (n) begin
      capture_input_pin_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      capture_input_pin_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask
  // A low level is a fault.
  task automatic fault(input logic lvl);
    compare_fault_input_o <= lvl;
  endtask
endmodule

// ### verif/ccc_tb.sv
// Self-checking bench of the capture and compare channel pair.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, run = 1'b0;
  logic cpu_idle_i = 1'b0, cpu_sleep_i = 1'b0, port_data_i = 1'b0, lastpin = 1'b0;
  logic [7:0] adr_i = 8'h0;
  logic [3:0] sel_i = 4'h3;
  logic [31:0] dat_i = 32'h0, dat_o, r;
  logic [15:0] timer_a_count_i = 16'h0, timer_b_count_i = 16'h8, first = 16'h0;
  logic ack_o, compare_output_pin_o, capture_irq_o, compare_irq_o;
  logic capture_input_pin_i, compare_fault_input_i;
  int mismatches = 0, samples_checked = 0, capirqs = 0, cmpirqs = 0, chg = 0;
  // Design and pin model.
  ccc_capture_compare dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .timer_a_count_i, .timer_b_count_i, .cpu_idle_i, .cpu_sleep_i,
    .capture_input_pin_i, .compare_fault_input_i, .port_data_i, .compare_output_pin_o,
    .capture_irq_o, .compare_irq_o);
  ccc_pin_model mdl (.clk_i, .capture_input_pin_o(capture_input_pin_i),
    .compare_fault_input_o(compare_fault_input_i));
  // A 40 MHz clock.
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // Time bases wrap at 40 and sit 8 apart, so a wrong select moves every match.
  always @(posedge clk_i) begin
    if (run) begin
      timer_a_count_i <= (timer_a_count_i == 16'h27) ? 16'h0 : timer_a_count_i + 16'h1;
      timer_b_count_i <= (timer_b_count_i == 16'h27) ? 16'h0 : timer_b_count_i + 16'h1;
    end
  end
  // Events are counted mid-cycle, away from the launching edge.
  always @(negedge clk_i) begin
    capirqs += (capture_irq_o === 1'b1);
    cmpirqs += (compare_irq_o === 1'b1);
    if (compare_output_pin_o !== lastpin) begin
      chg++;
      if (chg == 1) begin
        first = timer_a_count_i;
      end
    end
    lastpin = compare_output_pin_o;
  end
  task automatic final_report();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One classic cycle; a missing ack ends the run.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    if (ack_o !== 1'b1) begin
      mismatches++;
      final_report();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Capture: configure, send pulses, count events, then drain and check the words.
  task automatic cap_case(input logic [2:0] m, input logic [1:0] c, input logic t, s, i, z,
                          input int n, ne, ni);
    int k;
    bus(1'b1, 8'h00, 32'h0, r);
    bus(1'b1, 8'h00, {16'h0, 2'h0, s, 5'h0, t, c, 2'h3, m}, r);
    cpu_idle_i <= i;
    cpu_sleep_i <= z;
    capirqs = 0;
    mdl.pulses(n);
    cpu_idle_i <= 1'b0;
    cpu_sleep_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(capirqs, ni);
    bus(1'b0, 8'h00, 32'h0, r);
    chk(r[4:3], {ne > 4, ne > 0});
    k = 0;
    while (k < 5) begin
      bus(1'b0, 8'h00, 32'h0, r);
      if (r[3] !== 1'b1) break;
      bus(1'b0, 8'h04, 32'h0, r);
      chk(r, {16'h0, t ? timer_a_count_i : timer_b_count_i});
      k++;
    end
    chk(k, (ne > 4) ? 4 : ne);
  endtask
  // Compare: stop the time bases, program, check the start level, run and count edges.
  task automatic cmp_case(input logic [2:0] m, input logic t, input logic [15:0] p,
                          input int n, fa, input logic i0, input int ec, ei,
                          input logic [15:0] ef, input logic fv);
    run <= 1'b0;
    timer_a_count_i <= 16'h0;
    timer_b_count_i <= 16'h8;
    bus(1'b1, 8'h0c, {16'h0, p}, r);
    bus(1'b1, 8'h10, 32'h1e, r);
    bus(1'b1, 8'h08, {27'h1, t, m}, r);
    bus(1'b0, 8'h08, 32'h0, r);
    chk(r, {27'h0, t, m});
    repeat (2) @(posedge clk_i);
    chk(compare_output_pin_o, i0);
    chg = 0;
    cmpirqs = 0;
    first = 16'h0;
    lastpin = compare_output_pin_o;
    run <= 1'b1;
    for (int k = 1; k <= n; k++) begin
      @(posedge clk_i);
      if (k == fa) mdl.fault(1'b0);
      if (k == fa + 20) mdl.fault(1'b1);
    end
    run <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(chg, ec);
    chk(cmpirqs, ei);
    if (ef != 16'h0) chk(first, ef);
    chk(compare_output_pin_o, fv);
    bus(1'b0, 8'h08, 32'h0, r);
    chk(r[4], fa != 0);
  endtask
  // Compare halted in Idle: no match moves the pin until Idle ends; status shows the events.
  task automatic cmp_idle_case();
    run <= 1'b0;
    timer_a_count_i <= 16'h0;
    timer_b_count_i <= 16'h8;
    bus(1'b1, 8'h0c, 32'h14, r);
    bus(1'b1, 8'h08, 32'h2001, r);
    bus(1'b0, 8'h08, 32'h0, r);
    chk(r, 32'h2001);
    chg = 0;
    cmpirqs = 0;
    lastpin = compare_output_pin_o;
    cpu_idle_i <= 1'b1;
    run <= 1'b1;
    repeat (40) @(posedge clk_i);
    run <= 1'b0;
    cpu_idle_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(chg, 0);
    chk(cmpirqs, 0);
    run <= 1'b1;
    repeat (40) @(posedge clk_i);
    run <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(chg, 1);
    chk(cmpirqs, 1);
    bus(1'b0, 8'h14, 32'h0, r);
    chk(r, 32'h7);
    bus(1'b0, 8'h14, 32'h0, r);
    chk(r, 32'h4);
  endtask
  // Main sequence.
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a < 7; a++) begin
      bus(1'b0, 8'(a * 4), 32'h0, r);
      chk(r, 32'h0);
    end
    bus(1'b1, 8'h18, 32'hffff, r);
    bus(1'b0, 8'h18, 32'h0, r);
    chk(r, 32'h0);
    cap_case(3'h3, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1, 1, 1);
    cap_case(3'h3, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 4, 4, 2);
    cap_case(3'h3, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 4, 4, 1);
    cap_case(3'h3, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0, 5, 5, 1);
    cap_case(3'h1, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 2, 4, 4);
    cap_case(3'h2, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1, 1, 1);
    cap_case(3'h4, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 3, 0, 0);
    cap_case(3'h4, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 4, 1, 1);
    cap_case(3'h5, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 15, 0, 0);
    cap_case(3'h5, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 16, 1, 1);
    cap_case(3'h3, 2'h0, 1'b1, 1'b1, 1'b1, 1'b0, 2, 0, 0);
    cap_case(3'h3, 2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 2, 2, 2);
    cap_case(3'h7, 2'h0, 1'b1, 1'b0, 1'b0, 1'b1, 1, 0, 1);
    cap_case(3'h7, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1, 0, 0);
    cmp_case(3'h1, 1'b0, 16'h14, 98, 0, 1'b0, 1, 1, 16'h15, 1'b1);
    cmp_case(3'h3, 1'b0, 16'h14, 98, 0, 1'b1, 2, 2, 16'h15, 1'b1);
    cmp_case(3'h1, 1'b1, 16'h14, 98, 0, 1'b0, 1, 1, 16'hd, 1'b1);
    cmp_case(3'h2, 1'b0, 16'h14, 98, 0, 1'b1, 1, 1, 16'h15, 1'b0);
    cmp_case(3'h4, 1'b0, 16'h14, 98, 0, 1'b0, 2, 1, 16'h15, 1'b0);
    cmp_case(3'h5, 1'b0, 16'h14, 98, 0, 1'b0, 4, 2, 16'h15, 1'b0);
    cmp_case(3'h6, 1'b0, 16'h14, 98, 0, 1'b1, 4, 0, 16'h1f, 1'b1);
    cmp_case(3'h6, 1'b0, 16'h0, 10, 0, 1'b0, 0, 0, 16'h0, 1'b0);
    cmp_idle_case();
    cmp_case(3'h7, 1'b0, 16'h14, 98, 10, 1'b1, 1, 1, 16'h0, 1'b0);
    port_data_i <= 1'b1;
    cmp_case(3'h0, 1'b0, 16'h14, 10, 0, 1'b1, 0, 0, 16'h0, 1'b1);
    final_report();
  end
endmodule
// Checker on the design's ports.
bind ccc_capture_compare ccc_props chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .sel_i, .dat_i, .dat_o, .ack_o, .cpu_idle_i, .cpu_sleep_i, .compare_fault_input_i,
  .compare_output_pin_o, .capture_irq_o, .compare_irq_o);
